// ===== logic/reporter_pkg.sv
// Constants, types and state encodings for the power-up serial reporter.
// Assumes a single 10 MHz clock and a synchronous power-on reset.
//
// Functional notes
// - Send characters at 1200 bits per second.
// - Frame: start, eight bits LSB first, stop.
// - Non-inverted levels: start low, idle/stop high.
// - Measure and report unprompted after power-up.
// - Line low while measuring, high within 100 ms.
// - After reading, start sending with normal start bit.
// - After response enter SDI-12 mode, stay there.
// - Response opens with a tab character.
// - Dielectric, temperature, conductivity as spaced ASCII.
// - Carriage return closes the measurement values.
// - Sensor type character, then checksum character.
// - Checksum covers tab through sensor type.
// - Checksum is sum modulo 64 plus 32.
// - Response ends with carriage return, line feed.
// - Non-zero stored address suppresses the response.
package reporter_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_BPS = 1200;
  // Nearest whole cycle; 8333 gives a rate error well under one percent
  localparam int BIT_CYCLES = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
  localparam int RAISE_TIME_MS = 100;
  // Longest time, so rounded down
  localparam int RAISE_CYCLES = (CLK_HZ / 1000) * RAISE_TIME_MS;
  localparam int FRAME_BITS = 10;
  localparam int DATA_BITS = 8;
  localparam int BIT_CNT_W = 14;
  localparam int RAISE_CNT_W = 20;

  // ----------------------------------------------------------------
  // Buffer shape
  // ----------------------------------------------------------------
  localparam int BUF_WIDTH = 8;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CHAR_TAB = 8'h09;
  localparam logic [7:0] CHAR_LF = 8'h0A;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] CHAR_MINUS = 8'h2D;
  localparam logic [7:0] CHAR_DOT = 8'h2E;
  localparam logic [7:0] CHAR_ZERO = 8'h30;
  localparam logic [7:0] CHECK_OFFSET = 8'h20;
  localparam int CHECK_MOD = 64;
  localparam int CHECK_W = 6;
  // Arbitrary sensor type code
  localparam logic [7:0] SENSOR_TYPE_DEFAULT = 8'h74;
  localparam logic [7:0] ADDR_FACTORY = 8'h30;

  // ----------------------------------------------------------------
  // Response layout, one position per character slot
  // ----------------------------------------------------------------
  localparam logic [4:0] POS_TAB = 5'h00;
  localparam logic [4:0] POS_DIE_TENS = 5'h01;
  localparam logic [4:0] POS_DIE_ONES = 5'h02;
  localparam logic [4:0] POS_DIE_DOT = 5'h03;
  localparam logic [4:0] POS_DIE_TENTH = 5'h04;
  localparam logic [4:0] POS_SEP1 = 5'h05;
  localparam logic [4:0] POS_TMP_SIGN = 5'h06;
  localparam logic [4:0] POS_TMP_TENS = 5'h07;
  localparam logic [4:0] POS_TMP_ONES = 5'h08;
  localparam logic [4:0] POS_TMP_DOT = 5'h09;
  localparam logic [4:0] POS_TMP_TENTH = 5'h0A;
  localparam logic [4:0] POS_SEP2 = 5'h0B;
  localparam logic [4:0] POS_CND_4 = 5'h0C;
  localparam logic [4:0] POS_CND_0 = 5'h10;
  localparam logic [4:0] POS_CR1 = 5'h11;
  localparam logic [4:0] POS_TYPE = 5'h12;
  localparam logic [4:0] POS_CHECK = 5'h13;
  localparam logic [4:0] POS_CR2 = 5'h14;
  localparam logic [4:0] POS_LF = 5'h15;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_LOW = 3'h0,
    ST_WAIT = 3'h1,
    ST_SEND = 3'h3,
    ST_DRAIN = 3'h2,
    ST_DONE = 3'h6
  } phase_t;

  typedef struct packed {
    logic [3:0] die_tens;
    logic [3:0] die_ones;
    logic [3:0] die_tenth;
    logic temp_neg;
    logic [3:0] temp_tens;
    logic [3:0] temp_ones;
    logic [3:0] temp_tenth;
    logic [4:0][3:0] cond;
  } meas_t;

endpackage

// ===== logic/char_buffer.sv
// Two-entry character buffer between the response generator and the line driver.
// Assumes both sides on the same clock; either side may stall at any time.
`timescale 1ns/1ps
module char_buffer #(
  parameter int WIDTH = reporter_pkg::BUF_WIDTH,
  parameter int DEPTH = reporter_pkg::BUF_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] count;
  logic do_push;
  logic do_pop;

  assign in_ready = (count != (PTR_W+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = store[rd_ptr];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

// ===== logic/power_up_serial_reporter.sv
// Power-triggered one-shot serial reporter: measures, signals, sends one
// ASCII response unless a non-factory stored address suppresses it, then hands the line over to SDI-12 mode.
// Assumes measurement front end and address store on the same clock,
// and that power cycling drives reset_n.
`timescale 1ns/1ps
module power_up_serial_reporter #(
  parameter int BIT_CYCLES = reporter_pkg::BIT_CYCLES,
  parameter int RAISE_CYCLES = reporter_pkg::RAISE_CYCLES,
  parameter logic [7:0] SENSOR_TYPE = reporter_pkg::SENSOR_TYPE_DEFAULT,
  parameter bit NEWER_FIRMWARE = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] stored_addr,
  input wire logic meas_done,
  input wire reporter_pkg::meas_t meas_data,
  output logic meas_req,
  output logic data_out,
  output logic data_oe_n,
  output logic sdi12_mode
);

  reporter_pkg::phase_t phase;
  reporter_pkg::meas_t meas;
  logic have_data;
  logic [reporter_pkg::RAISE_CNT_W-1:0] raise_cnt;
  logic [4:0] pos;
  logic [reporter_pkg::CHECK_W-1:0] sum;
  logic [7:0] gen_char;
  logic gen_skip;
  logic gen_valid;
  logic push;
  logic advance;
  logic skip_resp;
  logic [4:0] lead_zero;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [7:0] buf_out_data;
  logic tx_ready;
  logic tx_busy;
  logic [reporter_pkg::FRAME_BITS-1:0] shift;
  logic [3:0] bit_idx;
  logic [reporter_pkg::BIT_CNT_W-1:0] bit_cnt;

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  assign skip_resp = NEWER_FIRMWARE && (stored_addr != reporter_pkg::ADDR_FACTORY);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase <= reporter_pkg::ST_LOW;
    end else begin
      case (phase)
        reporter_pkg::ST_LOW: begin
          // Two less than the count, as the phase and line registers each add a cycle before the pin rises
          if (raise_cnt == reporter_pkg::RAISE_CNT_W'(RAISE_CYCLES - 2)) begin
            phase <= reporter_pkg::ST_WAIT;
          end
        end
        reporter_pkg::ST_WAIT: begin
          if (skip_resp) begin
            phase <= reporter_pkg::ST_DONE;
          end else if (have_data) begin
            phase <= reporter_pkg::ST_SEND;
          end
        end
        reporter_pkg::ST_SEND: begin
          if (push && pos == reporter_pkg::POS_LF) begin
            phase <= reporter_pkg::ST_DRAIN;
          end
        end
        reporter_pkg::ST_DRAIN: begin
          if (!buf_out_valid && !tx_busy) begin
            phase <= reporter_pkg::ST_DONE;
          end
        end
        reporter_pkg::ST_DONE: begin
          phase <= reporter_pkg::ST_DONE;
        end
        default: begin
          phase <= reporter_pkg::ST_LOW;
        end
      endcase
    end
  end

  // Raising early is safe; only the deadline matters
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      raise_cnt <= '0;
    end else if (phase == reporter_pkg::ST_LOW) begin
      raise_cnt <= raise_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Measurement capture, one reading per power cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meas_req <= 1'b1;
      have_data <= 1'b0;
      meas <= '0;
    end else if (meas_done && !have_data) begin
      meas_req <= 1'b0;
      have_data <= 1'b1;
      meas <= meas_data;
    end
  end

  // ----------------------------------------------------------------
  // Response generator
  // ----------------------------------------------------------------
  // Conductivity digits from the top down that are still leading zeros
  assign lead_zero[4] = (meas.cond[4] == 4'h0);
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lead
      assign lead_zero[gi] = lead_zero[gi+1] && (meas.cond[gi] == 4'h0);
    end
  endgenerate

  always_comb begin
    gen_char = reporter_pkg::CHAR_SPACE;
    gen_skip = 1'b0;
    case (pos)
      reporter_pkg::POS_TAB: gen_char = reporter_pkg::CHAR_TAB;
      reporter_pkg::POS_DIE_TENS: begin
        gen_char = reporter_pkg::CHAR_ZERO + {4'h0, meas.die_tens};
        gen_skip = (meas.die_tens == 4'h0);
      end
      reporter_pkg::POS_DIE_ONES: gen_char = reporter_pkg::CHAR_ZERO + {4'h0, meas.die_ones};
      reporter_pkg::POS_DIE_DOT: gen_char = reporter_pkg::CHAR_DOT;
      reporter_pkg::POS_DIE_TENTH: gen_char = reporter_pkg::CHAR_ZERO + {4'h0, meas.die_tenth};
      reporter_pkg::POS_SEP1: gen_char = reporter_pkg::CHAR_SPACE;
      reporter_pkg::POS_TMP_SIGN: begin
        gen_char = reporter_pkg::CHAR_MINUS;
        gen_skip = !meas.temp_neg;
      end
      reporter_pkg::POS_TMP_TENS: begin
        gen_char = reporter_pkg::CHAR_ZERO + {4'h0, meas.temp_tens};
        gen_skip = (meas.temp_tens == 4'h0);
      end
      reporter_pkg::POS_TMP_ONES: gen_char = reporter_pkg::CHAR_ZERO + {4'h0, meas.temp_ones};
      reporter_pkg::POS_TMP_DOT: gen_char = reporter_pkg::CHAR_DOT;
      reporter_pkg::POS_TMP_TENTH: gen_char = reporter_pkg::CHAR_ZERO + {4'h0, meas.temp_tenth};
      reporter_pkg::POS_SEP2: gen_char = reporter_pkg::CHAR_SPACE;
      reporter_pkg::POS_CR1: gen_char = reporter_pkg::CHAR_CR;
      reporter_pkg::POS_TYPE: gen_char = SENSOR_TYPE;
      reporter_pkg::POS_CHECK: gen_char = {2'b00, sum} + reporter_pkg::CHECK_OFFSET;
      reporter_pkg::POS_CR2: gen_char = reporter_pkg::CHAR_CR;
      reporter_pkg::POS_LF: gen_char = reporter_pkg::CHAR_LF;
      default: begin
        if (pos >= reporter_pkg::POS_CND_4 && pos <= reporter_pkg::POS_CND_0) begin
          gen_char = reporter_pkg::CHAR_ZERO + {4'h0, meas.cond[3'(reporter_pkg::POS_CND_0 - pos)]};
          // Last digit always sent so a zero reading still shows
          gen_skip = (pos != reporter_pkg::POS_CND_0) && lead_zero[3'(reporter_pkg::POS_CND_0 - pos)];
        end
      end
    endcase
  end

  assign gen_valid = (phase == reporter_pkg::ST_SEND) && !gen_skip;
  assign push = gen_valid && buf_in_ready;
  assign advance = (phase == reporter_pkg::ST_SEND) && (gen_skip || buf_in_ready);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pos <= reporter_pkg::POS_TAB;
    end else if (advance && pos != reporter_pkg::POS_LF) begin
      pos <= pos + 1'b1;
    end
  end

  // Six-bit wrap gives the modulo for free
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sum <= '0;
    end else if (push && pos <= reporter_pkg::POS_TYPE) begin
      sum <= sum + gen_char[reporter_pkg::CHECK_W-1:0];
    end
  end

  char_buffer u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(gen_valid),
    .in_ready(buf_in_ready),
    .in_data(gen_char),
    .out_valid(buf_out_valid),
    .out_ready(tx_ready),
    .out_data(buf_out_data)
  );

  // ----------------------------------------------------------------
  // Line driver
  // ----------------------------------------------------------------
  assign tx_ready = !tx_busy && (phase == reporter_pkg::ST_SEND || phase == reporter_pkg::ST_DRAIN);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_busy <= 1'b0;
      shift <= '1;
      bit_idx <= '0;
      bit_cnt <= '0;
    end else if (!tx_busy) begin
      if (buf_out_valid && tx_ready) begin
        tx_busy <= 1'b1;
        shift <= {1'b1, buf_out_data, 1'b0};
        bit_idx <= '0;
        bit_cnt <= '0;
      end
    end else if (bit_cnt == reporter_pkg::BIT_CNT_W'(BIT_CYCLES - 1)) begin
      bit_cnt <= '0;
      shift <= {1'b1, shift[reporter_pkg::FRAME_BITS-1:1]};
      if (bit_idx == 4'(reporter_pkg::FRAME_BITS - 1)) begin
        tx_busy <= 1'b0;
      end else begin
        bit_idx <= bit_idx + 1'b1;
      end
    end else begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      data_out <= 1'b0;
      data_oe_n <= 1'b0;
      sdi12_mode <= 1'b0;
    end else begin
      case (phase)
        reporter_pkg::ST_LOW: data_out <= 1'b0;
        reporter_pkg::ST_SEND, reporter_pkg::ST_DRAIN: data_out <= tx_busy ? shift[0] : 1'b1;
        default: data_out <= 1'b1;
      endcase
      // Line released to the SDI-12 side once the response is out or skipped
      data_oe_n <= (phase == reporter_pkg::ST_DONE);
      sdi12_mode <= (phase == reporter_pkg::ST_DONE);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  logic [7:0] frame_byte;
  logic first_pushed;
  logic [11:0] chk_ref;
  logic [4:0] prev_push_pos;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      frame_byte <= '0;
      first_pushed <= 1'b0;
      chk_ref <= '0;
      prev_push_pos <= '0;
    end else begin
      if (!tx_busy && buf_out_valid && tx_ready) begin
        frame_byte <= buf_out_data;
      end
      if (push) begin
        first_pushed <= 1'b1;
        prev_push_pos <= pos;
      end
      if (push && pos <= reporter_pkg::POS_TYPE) begin
        chk_ref <= chk_ref + {4'h0, gen_char};
      end
    end
  end

  a_bit_period: assert property (tx_busy && $past(tx_busy) && $changed(bit_idx) |-> $past(bit_cnt) == BIT_CYCLES - 1)
    else $error("bit period wrong");
  a_start_low: assert property ($rose(tx_busy) |=> data_out == 1'b0)
    else $error("start bit not low");
  a_stop_high: assert property (tx_busy && bit_idx == 4'h9 && bit_cnt == 14'h0001 |-> data_out == 1'b1)
    else $error("stop bit not high");
  a_lsb_first: assert property (tx_busy && bit_idx >= 4'h1 && bit_idx <= 4'h8 && bit_cnt == 14'h0001
    |-> data_out == frame_byte[3'(bit_idx - 4'h1)])
    else $error("data bit order wrong");
  a_low_measure: assert property (phase == reporter_pkg::ST_LOW |=> !data_out && !data_oe_n)
    else $error("line not low while measuring");
  a_raise_deadline: assert property ($rose(raise_cnt == reporter_pkg::RAISE_CNT_W'(RAISE_CYCLES - 1)) |=> data_out)
    else $error("line raised too late");
  a_first_tab: assert property (push && !first_pushed |-> gen_char == reporter_pkg::CHAR_TAB)
    else $error("response does not open with tab");
  a_check_char: assert property (push && pos == reporter_pkg::POS_CHECK
    |-> prev_push_pos == reporter_pkg::POS_TYPE && gen_char == 8'((chk_ref % reporter_pkg::CHECK_MOD) + 32))
    else $error("checksum character wrong");
  a_end_lf: assert property ($rose(phase == reporter_pkg::ST_DRAIN) |-> $past(gen_char) == reporter_pkg::CHAR_LF)
    else $error("response not ended by line feed");
  a_done_stays: assert property (phase == reporter_pkg::ST_DONE |=> phase == reporter_pkg::ST_DONE && sdi12_mode)
    else $error("left SDI-12 mode");
  a_addr_quiet: assert property (skip_resp |-> phase != reporter_pkg::ST_SEND)
    else $error("response sent with non-zero address");

  c_sent: cover property (phase == reporter_pkg::ST_DRAIN ##1 phase == reporter_pkg::ST_DONE);
  c_skipped: cover property (phase == reporter_pkg::ST_WAIT && skip_resp);
  c_buf_full: cover property (phase == reporter_pkg::ST_SEND && !gen_skip && !buf_in_ready);
  c_frame_done: cover property ($fell(tx_busy));

endmodule

// ===== dv/serial_logger.sv
// Logger model: receives the sensor's power-up response off the data line.
// Assumes the bench switches sensor power through reset_n and resolves the line.
`timescale 1ns/1ps
module serial_logger #(
  parameter int BIT_CYCLES = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic line,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_stop
);
  // ------------------------------------------------------------
  // Receiver
  // ------------------------------------------------------------
  // Armed only once the line has gone high, so the measuring low is never taken for a start bit
  logic armed;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_stop = 1'b0;
    armed = 1'b0;
    forever begin
      @(posedge clk);
      rx_valid <= 1'b0;
      if (reset_n !== 1'b1) begin
        armed = 1'b0;
      end else if (line === 1'b1) begin
        armed = 1'b1;
      end else if (armed) begin
        // Low after high is a start bit; each bit is read at its middle
        repeat (BIT_CYCLES / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_CYCLES) @(posedge clk);
          rx_data[i] <= line;
        end
        repeat (BIT_CYCLES) @(posedge clk);
        rx_stop <= line;
        rx_valid <= 1'b1;
      end
    end
  end
endmodule

// ===== dv/power_up_serial_reporter_test.sv
// Bench for the power-up serial reporter: powers it up, feeds readings, checks the line.
// Assumes the reporter package and the logger model are compiled first.
`timescale 1ns/1ps
module power_up_serial_reporter_test;
  // ------------------------------------------------------------
  // Set-up
  // ------------------------------------------------------------
  // Short counts keep the run brief; every expectation derives from them
  localparam int BITS = 8;
  localparam int RAISE = 20;
  localparam int LIMIT = 20000;
  logic clk;
  logic reset_n;
  logic [7:0] stored_addr;
  logic meas_done;
  reporter_pkg::meas_t meas_data;
  logic meas_req;
  logic data_out;
  logic data_oe_n;
  logic sdi12_mode;
  logic line;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_stop;
  logic [7:0] rx_q[$];
  logic [7:0] exp_q[$];
  int errors;
  int n_compared;
  int cycles = 0;

  // The line has a pull-up, so it reads high once the sensor lets go
  assign line = data_oe_n ? 1'b1 : data_out;

  power_up_serial_reporter #(.BIT_CYCLES(BITS), .RAISE_CYCLES(RAISE)) dut (
    .clk(clk), .reset_n(reset_n), .stored_addr(stored_addr), .meas_done(meas_done),
    .meas_data(meas_data), .meas_req(meas_req), .data_out(data_out), .data_oe_n(data_oe_n),
    .sdi12_mode(sdi12_mode)
  );
  serial_logger #(.BIT_CYCLES(BITS)) logger (
    .clk(clk), .reset_n(reset_n), .line(line), .rx_valid(rx_valid), .rx_data(rx_data), .rx_stop(rx_stop)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic final_report();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (rx_valid === 1'b1) begin
      rx_q.push_back(rx_data);
      check(rx_stop, 1'b1);
    end
    if (cycles == LIMIT) begin
      errors++;
      $display("unexpected at %0t: run did not finish", $time);
      final_report();
    end
  end

  // Each transfer starts by switching the sensor's power, held off five cycles
  task automatic power_up(input logic [7:0] addr, input reporter_pkg::meas_t m);
    @(posedge clk);
    reset_n <= 1'b0;
    stored_addr <= addr;
    meas_data <= m;
    meas_done <= 1'b0;
    repeat (5) @(posedge clk);
    rx_q = {};
    reset_n <= 1'b1;
  endtask

  task automatic pulse_meas();
    @(negedge clk);
    check(meas_req, 1'b1);
    @(posedge clk);
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check(meas_req, 1'b0);
  endtask

  task automatic hold_level(input int n, input logic lvl);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge clk);
      if (data_out !== lvl || data_oe_n !== 1'b0) bad++;
    end
    check(8'(bad), 8'h00);
  endtask

  task automatic wait_mode(input int limit);
    int n;
    n = 0;
    while (sdi12_mode !== 1'b1 && n < limit) begin
      @(negedge clk);
      n++;
    end
    check(sdi12_mode, 1'b1);
    check(data_oe_n, 1'b1);
    repeat (2 * BITS) @(negedge clk);
  endtask

  function automatic logic [7:0] dig(input logic [3:0] d);
    return {4'h3, d};
  endfunction

  task automatic build_exp(input reporter_pkg::meas_t m);
    int sum;
    bit lead;
    exp_q = {reporter_pkg::CHAR_TAB};
    if (m.die_tens != 4'h0) exp_q.push_back(dig(m.die_tens));
    exp_q = {exp_q, dig(m.die_ones), reporter_pkg::CHAR_DOT, dig(m.die_tenth), reporter_pkg::CHAR_SPACE};
    if (m.temp_neg) exp_q.push_back(reporter_pkg::CHAR_MINUS);
    if (m.temp_tens != 4'h0) exp_q.push_back(dig(m.temp_tens));
    exp_q = {exp_q, dig(m.temp_ones), reporter_pkg::CHAR_DOT, dig(m.temp_tenth), reporter_pkg::CHAR_SPACE};
    lead = 1'b0;
    for (int i = 4; i >= 0; i--) begin
      if (m.cond[i] != 4'h0 || i == 0 || lead) begin
        exp_q.push_back(dig(m.cond[i]));
        lead = 1'b1;
      end
    end
    exp_q = {exp_q, reporter_pkg::CHAR_CR, reporter_pkg::SENSOR_TYPE_DEFAULT};
    sum = 0;
    foreach (exp_q[i]) sum += exp_q[i];
    exp_q = {exp_q, 8'((sum % 64) + 32), reporter_pkg::CHAR_CR, reporter_pkg::CHAR_LF};
  endtask

  task automatic compare_resp();
    int rsum;
    rsum = 0;
    check(8'(rx_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) begin
      check((i < rx_q.size()) ? rx_q[i] : 8'hFF, exp_q[i]);
    end
    // Logger side: recompute over what arrived, tab through type, and count an error on a mismatch
    for (int i = 0; i + 3 < rx_q.size(); i++) begin
      rsum += rx_q[i];
    end
    check((rx_q.size() > 3) ? rx_q[rx_q.size() - 3] : 8'hFF, 8'((rsum % 64) + 32));
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_early_reading();
    power_up(8'h30, {4'h2, 4'h2, 4'h0, 1'b0, 4'h2, 4'h1, 4'h2, 20'h01302});
    build_exp(meas_data);
    pulse_meas();
    hold_level(RAISE - 6, 1'b0);
    wait_mode(4000);
    compare_resp();
    // Sum of these codes plus the default type code gives 0x35
    check(rx_q[rx_q.size() - 3], 8'h35);
    // A later reading after the response must not bring a second one
    @(posedge clk);
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
    repeat (12 * BITS) @(negedge clk);
    check(8'(rx_q.size()), 8'(exp_q.size()));
    check(sdi12_mode, 1'b1);
  endtask

  task automatic s_addr_nonzero();
    power_up(8'h41, {4'h1, 4'h2, 4'h3, 1'b0, 4'h1, 4'h2, 4'h3, 20'h00456});
    pulse_meas();
    wait_mode(RAISE + 100);
    check(8'(rx_q.size()), 8'h00);
  endtask

  task automatic s_late_reading();
    power_up(8'h30, {4'h0, 4'h5, 4'h3, 1'b1, 4'h0, 4'h3, 4'h7, 20'h00000});
    build_exp(meas_data);
    hold_level(RAISE - 2, 1'b0);
    repeat (2) @(negedge clk);
    // No reading yet: high from RAISE cycles after release, with no start bit
    hold_level(6 * BITS + 4, 1'b1);
    pulse_meas();
    wait_mode(3000);
    compare_resp();
  endtask

  initial begin
    reset_n = 1'b0;
    stored_addr = 8'h30;
    meas_done = 1'b0;
    meas_data = '0;
    errors = 0;
    n_compared = 0;
    s_early_reading();
    s_addr_nonzero();
    s_late_reading();
    final_report();
  end
endmodule
